/* design/cac_control_mode.sv */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Set overflow flag on counter wrap to zero
// - Overflow flag with enable requests interrupt
// - Overflow enable masks overflow request
// - Event flags cleared only by software
// - Run bit starts and stops counter
// - Six module flags set on match/capture
// - Module flag with enable requests interrupt
// - Idle suspend freezes array while CPU idle
// - Watchdog enable resets to one
// - Lock blocks clearing watchdog enable
// - Timebase select picks increment source
// - Falling edges of external input count
// - External oscillator divided by eight, synced
// - Watchdog enabled freezes other mode bits
// - Unused mode bit reads zero
// - Watchdog forces counter run, run reads written
// - Writing module 5 flag forces watchdog reset
// - Low byte overflow at high match resets
module cac_control_mode (
   input wire logic clock,
   input wire logic rst,
   input wire logic clockEnable,
   input wire cac_pkg::cac_sfr_s sfr,
   output logic [7:0] sfrReadData,
   input wire logic cpuIdle,
   input wire logic [5:0] moduleEvent,
   input wire logic [5:0] moduleIrqEnable,
   input wire logic [7:0] module5CompareHigh,
   input wire logic timer0Overflow,
   input wire logic externalCountInput,
   input wire logic externalOscillator,
   output logic counterTick,
   output logic [15:0] counterValue,
   output logic watchdogActive,
   output logic counterArrayIrq,
   output logic watchdogReset
);
   import cac_pkg::*;

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic counterOverflowFlag;
   logic counterRun;
   logic [5:0] moduleEventFlag;
   logic idleSuspend;
   logic watchdogEnable;
   logic watchdogLock;
   logic [2:0] timebaseSelect;
   logic overflowIrqEnable;
   logic [15:0] counter;

   // ------------------------------------------------------------
   // Pin synchronisers and prescaler state
   // ------------------------------------------------------------
   logic extInMeta;
   logic extInSync;
   logic extInLast;
   logic oscMeta;
   logic oscSync;
   logic oscLast;
   logic [2:0] oscDivCount;
   logic [3:0] div12Count;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire logic writeControl = sfr.writeEn && (sfr.addr == CAC_ADDR_CONTROL);
   wire logic writeMode = sfr.writeEn && (sfr.addr == CAC_ADDR_MODE);
   wire logic readControlSel = (sfr.addr == CAC_ADDR_CONTROL);
   wire logic readModeSel = (sfr.addr == CAC_ADDR_MODE);

   // Suspend covers the whole array, prescalers included
   wire logic arrayActive = !(idleSuspend && cpuIdle);
   wire logic counterEnabled = (counterRun || watchdogEnable) && arrayActive;

   // ------------------------------------------------------------
   // Timebase sources
   // ------------------------------------------------------------
   wire logic div12Tick = (div12Count == CAC_DIV12_LAST);
   wire logic div4Tick = (div12Count[1:0] == CAC_DIV4_PHASE);
   wire logic extFallTick = extInLast && !extInSync;
   wire logic oscRise = oscSync && !oscLast;
   wire logic oscDiv8Tick = oscRise && (oscDivCount == CAC_OSC_DIV8_LAST);

   logic sourceTick;
   always_comb
   begin
      unique case (timebaseSelect)
         CAC_TB_DIV12: sourceTick = div12Tick;
         CAC_TB_DIV4: sourceTick = div4Tick;
         CAC_TB_TIMER0: sourceTick = timer0Overflow;
         CAC_TB_EXT_INPUT: sourceTick = extFallTick;
         CAC_TB_SYSCLK: sourceTick = 1'b1;
         CAC_TB_EXT_OSC: sourceTick = oscDiv8Tick;
         // Reserved codes leave the counter still
         default: sourceTick = 1'b0;
      endcase
   end

   wire logic tick = clockEnable && counterEnabled && sourceTick;
   wire logic counterWrap = tick && (counter == CAC_COUNTER_MAX);
   wire logic lowByteWrap = tick && (counter[7:0] == CAC_LOW_BYTE_MAX);
   wire logic watchdogTimeout = watchdogEnable && lowByteWrap
                                && (counter[15:8] == module5CompareHigh);
   wire logic watchdogForce = watchdogEnable && writeControl
                              && sfr.writeData[CAC_CTL_MOD5_BIT];

   // ------------------------------------------------------------
   // Flag next values: hardware set wins over software write
   // ------------------------------------------------------------
   wire logic [5:0] moduleSet = arrayActive ? moduleEvent : 6'h00;
   wire logic [5:0] next_moduleEventFlag =
      moduleSet | (writeControl ? sfr.writeData[5:0] : moduleEventFlag);
   wire logic next_counterOverflowFlag =
      counterWrap | (writeControl ? sfr.writeData[CAC_CTL_OVERFLOW_BIT]
                                  : counterOverflowFlag);
   wire logic next_counterRun =
      writeControl ? sfr.writeData[CAC_CTL_RUN_BIT] : counterRun;

   // ------------------------------------------------------------
   // Mode next values
   // ------------------------------------------------------------
   // Setting the lock also turns the watchdog on
   wire logic writeLock = sfr.writeData[CAC_MD_WDT_LOCK_BIT];
   wire logic modeOpen = writeMode && !watchdogEnable;
   wire logic next_watchdogLock = watchdogLock || (modeOpen && writeLock);
   logic next_watchdogEnable;
   always_comb
   begin
      next_watchdogEnable = watchdogEnable;
      if (modeOpen)
      begin
         next_watchdogEnable = sfr.writeData[CAC_MD_WDT_EN_BIT] || writeLock;
      end
      else if (writeMode && !watchdogLock)
      begin
         next_watchdogEnable = sfr.writeData[CAC_MD_WDT_EN_BIT];
      end
   end

   wire logic next_idleSuspend =
      modeOpen ? sfr.writeData[CAC_MD_IDLE_BIT] : idleSuspend;
   wire logic [2:0] next_timebaseSelect =
      modeOpen ? sfr.writeData[CAC_MD_TB_HI:CAC_MD_TB_LO] : timebaseSelect;
   wire logic next_overflowIrqEnable =
      modeOpen ? sfr.writeData[CAC_MD_OVF_IE_BIT] : overflowIrqEnable;

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   wire logic [7:0] controlView = {counterOverflowFlag, counterRun, moduleEventFlag};
   wire logic [7:0] modeView = {idleSuspend, watchdogEnable, watchdogLock, 1'b0,
                                timebaseSelect, overflowIrqEnable};
   wire logic [7:0] next_sfrReadData = readControlSel ? controlView
                                     : readModeSel ? modeView : 8'h00;

   // ------------------------------------------------------------
   // Synchronisers: first stage read by second only
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         extInMeta <= 1'b1;
         extInSync <= 1'b1;
         extInLast <= 1'b1;
         oscMeta <= 1'b0;
         oscSync <= 1'b0;
         oscLast <= 1'b0;
      end
      else if (clockEnable)
      begin
         extInMeta <= externalCountInput;
         extInSync <= extInMeta;
         extInLast <= extInSync;
         oscMeta <= externalOscillator;
         oscSync <= oscMeta;
         oscLast <= oscSync;
      end
   end

   // ------------------------------------------------------------
   // Prescalers
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         div12Count <= 4'h0;
         oscDivCount <= 3'h0;
      end
      else if (clockEnable && arrayActive)
      begin
         div12Count <= div12Tick ? 4'h0 : div12Count + 4'h1;
         if (oscRise)
         begin
            oscDivCount <= oscDivCount + 3'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         counter <= CAC_COUNTER_RESET;
      end
      else if (tick)
      begin
         counter <= counter + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // Control and mode registers
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         {counterOverflowFlag, counterRun, moduleEventFlag} <= CAC_CONTROL_RESET;
         idleSuspend <= CAC_MODE_RESET[CAC_MD_IDLE_BIT];
         watchdogEnable <= CAC_MODE_RESET[CAC_MD_WDT_EN_BIT];
         watchdogLock <= CAC_MODE_RESET[CAC_MD_WDT_LOCK_BIT];
         timebaseSelect <= CAC_MODE_RESET[CAC_MD_TB_HI:CAC_MD_TB_LO];
         overflowIrqEnable <= CAC_MODE_RESET[CAC_MD_OVF_IE_BIT];
      end
      else if (clockEnable)
      begin
         counterOverflowFlag <= next_counterOverflowFlag;
         counterRun <= next_counterRun;
         moduleEventFlag <= next_moduleEventFlag;
         idleSuspend <= next_idleSuspend;
         watchdogEnable <= next_watchdogEnable;
         watchdogLock <= next_watchdogLock;
         timebaseSelect <= next_timebaseSelect;
         overflowIrqEnable <= next_overflowIrqEnable;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Read data and reset are registered to keep them glitch free
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sfrReadData <= 8'h00;
         watchdogReset <= 1'b0;
      end
      else if (clockEnable)
      begin
         sfrReadData <= next_sfrReadData;
         watchdogReset <= watchdogTimeout || watchdogForce;
      end
   end

   assign counterTick = tick;
   assign counterValue = counter;
   assign watchdogActive = watchdogEnable;
   assign counterArrayIrq = (counterOverflowFlag && overflowIrqEnable)
                            || |(moduleEventFlag & moduleIrqEnable);
endmodule
`default_nettype wire

/* pkg/cac_pkg.sv */
`default_nettype none
package cac_pkg;
   // ------------------------------------------------------------
   // Register offsets in special function register space
   // ------------------------------------------------------------
   localparam logic [7:0] CAC_ADDR_CONTROL = 8'hd8;
   localparam logic [7:0] CAC_ADDR_MODE = 8'hd9;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] CAC_CONTROL_RESET = 8'h00;
   localparam logic [7:0] CAC_MODE_RESET = 8'h40;
   localparam logic [15:0] CAC_COUNTER_RESET = 16'h0000;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int CAC_CTL_OVERFLOW_BIT = 7;
   localparam int CAC_CTL_RUN_BIT = 6;
   localparam int CAC_CTL_MOD5_BIT = 5;
   localparam int CAC_NUM_MODULES = 6;

   // ------------------------------------------------------------
   // Mode register fields
   // ------------------------------------------------------------
   localparam int CAC_MD_IDLE_BIT = 7;
   localparam int CAC_MD_WDT_EN_BIT = 6;
   localparam int CAC_MD_WDT_LOCK_BIT = 5;
   localparam int CAC_MD_UNUSED_BIT = 4;
   localparam int CAC_MD_TB_HI = 3;
   localparam int CAC_MD_TB_LO = 1;
   localparam int CAC_MD_OVF_IE_BIT = 0;

   // ------------------------------------------------------------
   // Timebase select codes and prescaler counts
   // ------------------------------------------------------------
   localparam logic [2:0] CAC_TB_DIV12 = 3'h0;
   localparam logic [2:0] CAC_TB_DIV4 = 3'h1;
   localparam logic [2:0] CAC_TB_TIMER0 = 3'h2;
   localparam logic [2:0] CAC_TB_EXT_INPUT = 3'h3;
   localparam logic [2:0] CAC_TB_SYSCLK = 3'h4;
   localparam logic [2:0] CAC_TB_EXT_OSC = 3'h5;
   localparam logic [3:0] CAC_DIV12_LAST = 4'hb;
   localparam logic [1:0] CAC_DIV4_PHASE = 2'h3;
   localparam logic [2:0] CAC_OSC_DIV8_LAST = 3'h7;
   localparam logic [7:0] CAC_LOW_BYTE_MAX = 8'hff;
   localparam logic [15:0] CAC_COUNTER_MAX = 16'hffff;

   // ------------------------------------------------------------
   // Register port carrier
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic writeEn;
      logic [7:0] writeData;
   } cac_sfr_s;
endpackage
`default_nettype wire

/* bench/cac_control_mode_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module cac_control_mode_chk (
   input wire logic clock,
   input wire logic rst,
   input wire logic clockEnable,
   input wire cac_pkg::cac_sfr_s sfr,
   input wire logic [7:0] sfrReadData,
   input wire logic cpuIdle,
   input wire logic [5:0] moduleEvent,
   input wire logic [5:0] moduleIrqEnable,
   input wire logic [7:0] module5CompareHigh,
   input wire logic counterTick,
   input wire logic [15:0] counterValue,
   input wire logic watchdogActive,
   input wire logic counterArrayIrq,
   input wire logic watchdogReset
);
   import cac_pkg::*;
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   wire logic modeClr = clockEnable && sfr.writeEn && sfr.addr == CAC_ADDR_MODE && !sfr.writeData[6];
   // ----------------------------------------
   // Multi-step causes
   // ----------------------------------------
   sequence evtSet;
      clockEnable && !cpuIdle && (moduleEvent & moduleIrqEnable) != 6'h00;
   endsequence
   sequence lowWrap;
      clockEnable && watchdogActive && counterTick && counterValue[7:0] == CAC_LOW_BYTE_MAX
         && counterValue[15:8] == module5CompareHigh;
   endsequence
   wrap_to_zero_a: assert property (clockEnable && counterTick && counterValue == CAC_COUNTER_MAX
      |=> counterValue == 16'h0000) else $error("no wrap");
   no_tick_hold_a: assert property (!(clockEnable && counterTick) |=> $stable(counterValue))
      else $error("count moved");
   tick_step_a: assert property (clockEnable && counterTick
      |=> counterValue == $past(counterValue) + 16'h0001) else $error("bad step");
   event_irq_a: assert property (evtSet ##1 $stable(moduleIrqEnable) |-> counterArrayIrq)
      else $error("no irq");
   unused_zero_a: assert property (clockEnable && sfr.addr == CAC_ADDR_MODE |=> !sfrReadData[4])
      else $error("bit4 set");
   sw_force_a: assert property (clockEnable && watchdogActive && sfr.writeEn
      && sfr.addr == CAC_ADDR_CONTROL && sfr.writeData[5] |=> watchdogReset) else $error("no force");
   wd_match_a: assert property (lowWrap |=> watchdogReset) else $error("no timeout");
   wd_drop_a: assert property ($fell(watchdogActive) |-> $past(modeClr))
      else $error("bad drop");
endmodule
bind cac_control_mode cac_control_mode_chk chkInst (.clock, .rst, .clockEnable, .sfr, .sfrReadData,
   .cpuIdle, .moduleEvent, .moduleIrqEnable, .module5CompareHigh, .counterTick, .counterValue,
   .watchdogActive, .counterArrayIrq, .watchdogReset);
`default_nettype wire

/* bench/cac_control_mode_test.sv */
`timescale 1ns/1ns
`default_nettype none
module cac_control_mode_test;
   import cac_pkg::*;
   logic clock = 1'b0, rst = 1'b1, cpuIdle = 1'b0, t0 = 1'b0, extIn = 1'b1, extOsc = 1'b0, ce = 1'b1;
   logic tick, wdActive, irq, wdReset;
   cac_sfr_s sfr = '0;
   logic [5:0] evt = '0, irqEn = '0;
   logic [7:0] cmpHigh = '0, rdData;
   logic [15:0] cnt, v0;
   logic [7:0] mdTab [10] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h88, 8'h08};
   logic [15:0] exTab [10] = '{16'h4, 16'hc, 16'h5, 16'h5, 16'h30, 16'h2, 16'h0, 16'h0, 16'h0, 16'h30};
   logic [9:0] idleTab = 10'h300;
   int failCount = 0, compares = 0, cycles = 0;
   always #25 clock = ~clock;
   cac_control_mode DUT (.clock, .rst, .clockEnable(ce), .sfr, .sfrReadData(rdData), .cpuIdle,
      .moduleEvent(evt), .moduleIrqEnable(irqEn), .module5CompareHigh(cmpHigh), .timer0Overflow(t0),
      .externalCountInput(extIn), .externalOscillator(extOsc), .counterTick(tick), .counterValue(cnt),
      .watchdogActive(wdActive), .counterArrayIrq(irq), .watchdogReset(wdReset));
   task automatic finishTest;
      $display("compares %0d mismatches %0d", compares, failCount);
      if (failCount == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         failCount++;
      end
   endtask
   // ----------------------------------------
   // Register access, one idle cycle first
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, d, input logic [5:0] e = 6'h00);
      @(posedge clock) #5;
      sfr = '{a, 1'b1, d};
      evt = e;
      @(posedge clock) #5;
      sfr.writeEn = 1'b0;
      evt = 6'h00;
   endtask
   task automatic rd(input logic [7:0] a, e);
      @(posedge clock) #5;
      sfr.addr = a;
      @(posedge clock) #5;
      chk("read", {8'h00, e}, {8'h00, rdData});
   endtask
   // Windows of 48 cycles hold whole prescaler periods, so start phase does not matter
   task automatic measure(input logic [7:0] md, input logic idle, input logic [15:0] e);
      wr(8'hd9, md);
      cpuIdle = idle;
      v0 = cnt;
      for (int i = 0; i < 48; i++)
      begin
         t0 = md[3:1] == 3'h2 && i < 10 && i[0];
         extIn = !(md[3:1] == 3'h3 && i < 20 && i[1]);
         extOsc = md[3:1] == 3'h5 && i < 32 && i[0];
         @(posedge clock) #5;
      end
      cpuIdle = 1'b0;
      chk("count delta", e, cnt - v0);
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 90000)
      begin
         failCount++;
         finishTest();
      end
   end
   initial
   begin
      repeat (10) @(posedge clock) #5;
      rst = 0;
      rd(8'hd8, 8'h00);
      rd(8'hd9, 8'h40);
      rd(8'h80, 8'h00);
      wr(8'hd9, 8'h5f);
      rd(8'hd9, 8'h40);
      wr(8'hd9, 8'h1f);
      rd(8'hd9, 8'h00);
      wr(8'hd9, 8'h1f);
      rd(8'hd9, 8'h0f);
      wr(8'hd8, 8'h00);
      measure(8'h08, 0, 0);
      wr(8'hd8, 8'h40);
      for (int k = 0; k < 10; k++)
         measure(mdTab[k], idleTab[k], exTab[k]);
      irqEn = 6'h01;
      wr(8'hd8, 8'h00, 6'h3f);
      rd(8'hd8, 8'h3f);
      for (int k = 0; k < 6; k++)
      begin
         irqEn = 6'h01 << k;
         @(posedge clock) #5;
         chk("module irq", 16'h0001, {15'h0000, irq});
      end
      irqEn = 6'h00;
      wr(8'hd8, 8'h40);
      for (int k = 0; k < 70000 && cnt !== 16'hffff; k++)
         @(posedge clock) #5;
      rd(8'hd8, 8'hc0);
      chk("irq masked", 16'h0000, {15'h0000, irq});
      wr(8'hd9, 8'h09);
      chk("irq", 16'h0001, {15'h0000, irq});
      wr(8'hd8, 8'h40);
      chk("irq cleared", 16'h0000, {15'h0000, irq});
      wr(8'hd9, 8'h48);
      cmpHigh = cnt[15:8] + 8'h01;
      for (int k = 0; k < 600 && wdReset !== 1'b1; k++)
         @(posedge clock) #5;
      chk("timeout reset", 16'h0001, {15'h0000, wdReset});
      wr(8'hd8, 8'h20);
      chk("forced reset", 16'h0001, {15'h0000, wdReset});
      rd(8'hd8, 8'h20);
      v0 = cnt;
      @(posedge clock) #5;
      chk("forced run", 16'h0001, cnt - v0);
      // Clock enable low must hold the forced count still
      ce = 1'b0;
      v0 = cnt;
      repeat (4) @(posedge clock) #5;
      chk("frozen count", 16'h0000, cnt - v0);
      ce = 1'b1;
      wr(8'hd9, 8'h00);
      chk("enable", 16'h0000, {15'h0000, wdActive});
      wr(8'hd9, 8'h20);
      rd(8'hd9, 8'h60);
      wr(8'hd9, 8'h00);
      chk("locked", 16'h0001, {15'h0000, wdActive});
      rst = 1'b1;
      repeat (2) @(posedge clock) #5;
      rst = 1'b0;
      wr(8'hd9, 8'h00);
      chk("unlocked", 16'h0000, {15'h0000, wdActive});
      finishTest();
   end
endmodule
`default_nettype wire
